// >>> common/bl_seq_pkg.sv
// constants, field layouts and state type of the backlight power sequencer
package bl_seq_pkg;
  // lane geometry: eight receive lanes, one pixel word per lane
  localparam int LANES = 8;
  localparam int PIXEL_W = 30;
  localparam int GROUP_W = LANES * PIXEL_W;
  // register port
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] CLEAR_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] ENABLE_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] STATE_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] CONTROL_OFS = 8'h10;
  // event bits of status, clear and enable
  localparam int NUM_EV = 4;
  localparam int EV_FAULT = 0;
  localparam int EV_SEQ = 1;
  localparam int EV_PWM_CHG = 2;
  localparam int EV_LOCK_CHG = 3;
  // control and state fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;
  localparam logic [NUM_EV-1:0] ENABLE_RESET = 4'h0;
  localparam int STATE_LSB = 0;
  localparam int ST_FAULT_BIT = 4;
  localparam int ST_LOCK_BIT = 5;
  localparam int ST_MODE2D_BIT = 6;
  localparam int ST_LOCAL_BIT = 7;
  localparam int ST_PULSE_BIT = 8;
  // timing: 250 MHz clock, least delays rounded up to whole cycles
  localparam longint CLOCK_HZ = 250000000;
  localparam longint PWM_DELAY_MS = 100;
  localparam longint ON_DELAY_MS = 300;
  localparam longint OFF_TIME_MS = 300;
  localparam longint TURN_ON_MS = 300;
  localparam int PWM_DELAY_CYC = int'((PWM_DELAY_MS * CLOCK_HZ + 999) / 1000);
  localparam int ON_DELAY_CYC = int'((ON_DELAY_MS * CLOCK_HZ + 999) / 1000);
  localparam int OFF_TIME_CYC = int'((OFF_TIME_MS * CLOCK_HZ + 999) / 1000);
  localparam int TURN_ON_CYC = int'((TURN_ON_MS * CLOCK_HZ + 999) / 1000);
  // allowed wobble of the dimming period during turn-on, in cycles
  localparam logic [23:0] PWM_TOL = 24'h00_0100;
  typedef enum logic [2:0] {st_off, st_supply, st_ready, st_turn_on, st_on, st_fault} seq_e;
endpackage

// >>> common/lane_group_if.sv
// carrier between the sequencer top and the lane ordering stage
`timescale 1ns/1ns
interface lane_group_if;
  logic [bl_seq_pkg::LANES-1:0] lane_lock;
  logic lane_valid;
  logic [bl_seq_pkg::GROUP_W-1:0] lane_data;
  logic [bl_seq_pkg::GROUP_W-1:0] pixel_group;
  logic pixel_valid;
  logic all_locked;
  modport rx (input lane_lock, lane_valid, lane_data, output pixel_group, pixel_valid,
    all_locked);
  modport user (output lane_lock, lane_valid, lane_data, input pixel_group, pixel_valid,
    all_locked);
endinterface

// >>> design/lane_order.sv
// orders the eight lane words into one pixel group and summarises lock
`timescale 1ns/1ns
module lane_order
(
  input wire logic clock,
  input wire logic rst_b,
  lane_group_if.rx lanes
);
  // lane i carries pixel i+1 of each group of eight
  genvar i;
  generate
    for (i = 0; i < bl_seq_pkg::LANES; i++)
    begin : g_lane
      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
          lanes.pixel_group[i*bl_seq_pkg::PIXEL_W +: bl_seq_pkg::PIXEL_W] <= '0;
        else if (lanes.lane_valid)
          lanes.pixel_group[i*bl_seq_pkg::PIXEL_W +: bl_seq_pkg::PIXEL_W] <=
            lanes.lane_data[i*bl_seq_pkg::PIXEL_W +: bl_seq_pkg::PIXEL_W];
      end
    end
  endgenerate

  // group valid and lock summary, one stage like the data
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lanes.pixel_valid <= 1'b0;
      lanes.all_locked <= 1'b0;
    end
    else
    begin
      lanes.pixel_valid <= lanes.lane_valid;
      lanes.all_locked <= &lanes.lane_lock;
    end
  end
endmodule // lane_order

// >>> design/backlight_power_sequencer.sv
// backlight converter sequencer with fault flag, lock indicator and lane ordering
// Operation
// - fault flag held at ground normally, released open when protection trips in turn-on or on
// - external dimming pulse is honoured only in 2D mode
// - open-drain lock indicator shows whether the serial receivers locked
// - lanes 0 to 7 carry pixels 1 to 8 of each eight-pixel group
// - local-dimming select input lets the host choose local dimming operation
`timescale 1ns/1ns
module backlight_power_sequencer
#(
  parameter int PWM_DELAY_CYC = bl_seq_pkg::PWM_DELAY_CYC,
  parameter int ON_DELAY_CYC = bl_seq_pkg::ON_DELAY_CYC,
  parameter int OFF_TIME_CYC = bl_seq_pkg::OFF_TIME_CYC,
  parameter int TURN_ON_CYC = bl_seq_pkg::TURN_ON_CYC
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic backlight_supply,
  input wire logic external_dimming_pulse,
  input wire logic backlight_on_ctl,
  input wire logic mode_2d,
  input wire logic local_dim_select,
  input wire logic local_dim_pulse,
  input wire logic protect_trip,
  input wire logic [bl_seq_pkg::LANES-1:0] lane_lock,
  input wire logic lane_valid,
  input wire logic [bl_seq_pkg::GROUP_W-1:0] lane_data,
  input wire logic [bl_seq_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  output logic irq,
  output logic lamp_drive,
  output logic fault_flag_out,
  output logic fault_flag_oe,
  output logic link_lock_indicator_out,
  output logic link_lock_indicator_oe,
  output logic [bl_seq_pkg::GROUP_W-1:0] pixel_group,
  output logic pixel_valid
);
  bl_seq_pkg::seq_e state_reg;
  bl_seq_pkg::seq_e state_next;
  logic [31:0] tmr_reg;
  logic [31:0] off_reg;
  logic [31:0] supply_tmr_reg;
  logic on_q_reg;
  logic pwm_q_reg;
  logic pulse_seen_reg;
  logic [23:0] per_cnt_reg;
  logic [23:0] per_ref_reg;
  logic per_ref_ok_reg;
  logic lock_q_reg;
  logic [bl_seq_pkg::NUM_EV-1:0] status_reg;
  logic [bl_seq_pkg::NUM_EV-1:0] status_next;
  logic [bl_seq_pkg::NUM_EV-1:0] enable_reg;
  logic [bl_seq_pkg::NUM_EV-1:0] ev;
  logic [31:0] control_reg;
  logic on_rise;
  logic pwm_rise;
  logic on_allowed;
  logic [23:0] per_diff;
  lane_group_if lanes ();

  assign lanes.lane_lock = lane_lock;
  assign lanes.lane_valid = lane_valid;
  assign lanes.lane_data = lane_data;
  assign on_rise = backlight_on_ctl && !on_q_reg;
  assign pwm_rise = external_dimming_pulse && !pwm_q_reg;

  lane_order u_lane_order (.clock(clock), .rst_b(rst_b), .lanes(lanes));

  // the turn-on request is only honoured when supply, pulse and spacing are in order
  assign on_allowed = backlight_supply && pulse_seen_reg
    && control_reg[bl_seq_pkg::CTRL_ENABLE_BIT] && tmr_reg >= 32'(ON_DELAY_CYC)
    && off_reg >= 32'(OFF_TIME_CYC);

  // sequencer next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      bl_seq_pkg::st_off:
        if (backlight_supply)
          state_next = bl_seq_pkg::st_supply;
      bl_seq_pkg::st_supply:
        if (!backlight_supply)
          state_next = bl_seq_pkg::st_off;
        else if (pulse_seen_reg)
          state_next = bl_seq_pkg::st_ready;
      bl_seq_pkg::st_ready:
        if (!backlight_supply)
          state_next = bl_seq_pkg::st_off;
        else if (on_rise && on_allowed)
          state_next = bl_seq_pkg::st_turn_on;
      bl_seq_pkg::st_turn_on, bl_seq_pkg::st_on:
        if (protect_trip)
          state_next = bl_seq_pkg::st_fault;
        else if (!backlight_supply)
          state_next = bl_seq_pkg::st_off;
        else if (!backlight_on_ctl)
          state_next = bl_seq_pkg::st_ready;
        else if (state_reg == bl_seq_pkg::st_turn_on && tmr_reg >= 32'(TURN_ON_CYC))
          state_next = bl_seq_pkg::st_on;
      bl_seq_pkg::st_fault:
        if (!backlight_supply)
          state_next = bl_seq_pkg::st_off; // fault latches until the supply is cut
      default:
        state_next = bl_seq_pkg::st_off;
    endcase
  end

  // state and step timer; the timer restarts on every state change
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= bl_seq_pkg::st_off;
      tmr_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_next != state_reg)
        tmr_reg <= '0;
      else if (tmr_reg != 32'hffff_ffff)
        tmr_reg <= tmr_reg + 32'h1;
    end
  end

  // off time since the on control fell; starts satisfied after reset
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      off_reg <= 32'hffff_ffff;
    else if (backlight_on_ctl)
      off_reg <= '0;
    else if (off_reg != 32'hffff_ffff)
      off_reg <= off_reg + 32'h1;
  end

  // time since supply came up, for the pulse start spacing
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      supply_tmr_reg <= '0;
    else if (!backlight_supply)
      supply_tmr_reg <= '0;
    else if (supply_tmr_reg != 32'hffff_ffff)
      supply_tmr_reg <= supply_tmr_reg + 32'h1;
  end

  // pulse presence: a constant high level counts too, since full duty is legal
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pulse_seen_reg <= 1'b0;
      pwm_q_reg <= 1'b0;
      on_q_reg <= 1'b0;
    end
    else
    begin
      pwm_q_reg <= external_dimming_pulse;
      on_q_reg <= backlight_on_ctl;
      if (!backlight_supply)
        pulse_seen_reg <= 1'b0;
      else if (external_dimming_pulse || !mode_2d)
        pulse_seen_reg <= 1'b1;
    end
  end

  // dimming period measured between rising edges, frozen as reference at turn-on
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      per_cnt_reg <= '0;
      per_ref_reg <= '0;
      per_ref_ok_reg <= 1'b0;
    end
    else
    begin
      per_cnt_reg <= pwm_rise ? 24'h00_0001 : per_cnt_reg + 24'h00_0001;
      if (state_reg != bl_seq_pkg::st_turn_on)
        per_ref_ok_reg <= 1'b0;
      else if (pwm_rise && !per_ref_ok_reg)
      begin
        per_ref_reg <= per_cnt_reg;
        per_ref_ok_reg <= 1'b1;
      end
    end
  end

  assign per_diff = (per_cnt_reg > per_ref_reg) ? per_cnt_reg - per_ref_reg
    : per_ref_reg - per_cnt_reg;

  // events: trip, sequence fault, waveform change in turn-on, lock change
  always_comb
  begin
    ev = '0;
    ev[bl_seq_pkg::EV_FAULT] = protect_trip && state_reg != bl_seq_pkg::st_fault;
    ev[bl_seq_pkg::EV_SEQ] = (state_reg == bl_seq_pkg::st_ready && on_rise && !on_allowed)
      || (on_rise && state_reg <= bl_seq_pkg::st_supply)
      || (pwm_rise && backlight_supply && !pulse_seen_reg
      && supply_tmr_reg < 32'(PWM_DELAY_CYC));
    ev[bl_seq_pkg::EV_PWM_CHG] = state_reg == bl_seq_pkg::st_turn_on && mode_2d && pwm_rise
      && per_ref_ok_reg && per_diff > bl_seq_pkg::PWM_TOL;
    ev[bl_seq_pkg::EV_LOCK_CHG] = lanes.all_locked != lock_q_reg;
  end

  // sticky status: a new event wins over a clear in the same cycle
  assign status_next = (status_reg & ~((wr_en && addr == bl_seq_pkg::CLEAR_OFS)
    ? wr_data[bl_seq_pkg::NUM_EV-1:0] : '0)) | ev;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_reg <= '0;
      enable_reg <= bl_seq_pkg::ENABLE_RESET;
      control_reg <= bl_seq_pkg::CONTROL_RESET;
      irq <= 1'b0;
      lock_q_reg <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      lock_q_reg <= lanes.all_locked;
      irq <= |(status_next & ((wr_en && addr == bl_seq_pkg::ENABLE_OFS)
        ? wr_data[bl_seq_pkg::NUM_EV-1:0] : enable_reg));
      if (wr_en && addr == bl_seq_pkg::ENABLE_OFS)
        enable_reg <= wr_data[bl_seq_pkg::NUM_EV-1:0];
      if (wr_en && addr == bl_seq_pkg::CONTROL_OFS)
        control_reg <= {31'h0, wr_data[bl_seq_pkg::CTRL_ENABLE_BIT]};
    end
  end

  // read port; clear register and unmapped addresses read as zero
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      rd_data <= '0;
    else if (rd_en)
    begin
      rd_data <= '0;
      case (addr)
        bl_seq_pkg::STATUS_OFS: rd_data[bl_seq_pkg::NUM_EV-1:0] <= status_reg;
        bl_seq_pkg::ENABLE_OFS: rd_data[bl_seq_pkg::NUM_EV-1:0] <= enable_reg;
        bl_seq_pkg::CONTROL_OFS: rd_data <= control_reg;
        bl_seq_pkg::STATE_OFS:
        begin
          rd_data[bl_seq_pkg::STATE_LSB +: 3] <= state_reg;
          rd_data[bl_seq_pkg::ST_FAULT_BIT] <= state_reg == bl_seq_pkg::st_fault;
          rd_data[bl_seq_pkg::ST_LOCK_BIT] <= lanes.all_locked;
          rd_data[bl_seq_pkg::ST_MODE2D_BIT] <= mode_2d;
          rd_data[bl_seq_pkg::ST_LOCAL_BIT] <= local_dim_select;
          rd_data[bl_seq_pkg::ST_PULSE_BIT] <= pulse_seen_reg;
        end
        default: rd_data <= '0;
      endcase
    end
  end

  // pins: lamp, fault flag, lock indicator and the ordered pixel group
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lamp_drive <= 1'b0;
      fault_flag_out <= 1'b0;
      fault_flag_oe <= 1'b1;
      link_lock_indicator_out <= 1'b0;
      link_lock_indicator_oe <= 1'b0;
      pixel_group <= '0;
      pixel_valid <= 1'b0;
    end
    else
    begin
      if (state_reg != bl_seq_pkg::st_turn_on && state_reg != bl_seq_pkg::st_on)
        lamp_drive <= 1'b0;
      else if (local_dim_select)
        lamp_drive <= local_dim_pulse;
      else
        lamp_drive <= mode_2d ? external_dimming_pulse : 1'b1;
      fault_flag_oe <= state_reg != bl_seq_pkg::st_fault;
      link_lock_indicator_oe <= lanes.all_locked;
      pixel_group <= lanes.pixel_group;
      pixel_valid <= lanes.pixel_valid;
    end
  end

  // fault flag released one cycle after the fault state is entered
  fault_release_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg != bl_seq_pkg::st_fault) ##1 (state_reg == bl_seq_pkg::st_fault)
    |=> !fault_flag_oe && !fault_flag_out)
    else $error("fault flag not released after protection trip");
  fault_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    $past(state_reg) != bl_seq_pkg::st_fault |-> fault_flag_oe)
    else $error("fault flag not held low in normal operation");
  dim_2d_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == bl_seq_pkg::st_on && mode_2d && !local_dim_select)
    |=> lamp_drive == $past(external_dimming_pulse))
    else $error("lamp does not follow dimming pulse in 2D mode");
  dim_non2d_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == bl_seq_pkg::st_on && !mode_2d && !local_dim_select) |=> lamp_drive)
    else $error("dimming pulse honoured outside 2D mode");
  local_dim_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == bl_seq_pkg::st_on && local_dim_select) |=> lamp_drive == $past(local_dim_pulse))
    else $error("local dimming select ignored");
  lock_ind_a: assert property (@(posedge clock) disable iff (!rst_b)
    ##1 (&lane_lock) [*3] |-> link_lock_indicator_oe && !link_lock_indicator_out)
    else $error("lock indicator not driven after lanes locked");
  lane_map_a: assert property (@(posedge clock) disable iff (!rst_b)
    lane_valid |-> ##2 pixel_valid && pixel_group[bl_seq_pkg::PIXEL_W-1:0]
    == $past(lane_data[bl_seq_pkg::PIXEL_W-1:0], 2))
    else $error("lane 0 not mapped to first pixel");
  // pulse presence is a condition of ready, so the refusal is watched through on_allowed
  seq_refuse_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == bl_seq_pkg::st_ready && on_rise && !on_allowed)
    |=> state_reg != bl_seq_pkg::st_turn_on && status_reg[bl_seq_pkg::EV_SEQ])
    else $error("on control accepted out of sequence");
endmodule // backlight_power_sequencer

// >>> testbench/host_board_model.sv
// host board model: converter supply, dimming pulse and on control in order
`timescale 1ns/1ns
module host_board_model
#(
  parameter int PWM_GAP = 24,
  parameter int ON_GAP = 48,
  parameter int PERIOD = 16,
  parameter int HIGH = 8
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic power_up,
  output logic backlight_supply,
  output logic external_dimming_pulse,
  output logic backlight_on_ctl
);
  logic [7:0] step_reg;
  logic [7:0] phase_reg;
  logic run_reg;
  // fixed period and half duty, far from the banned band near full duty
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      phase_reg <= 8'h00;
    else
      phase_reg <= (phase_reg == 8'(PERIOD - 1)) ? 8'h00 : phase_reg + 8'h01;
  assign external_dimming_pulse = run_reg && (phase_reg < 8'(HIGH));
  // up: supply, pulse, on with margins; down: one step a cycle, reversed
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      step_reg <= 8'h00;
      backlight_supply <= 1'b0;
      run_reg <= 1'b0;
      backlight_on_ctl <= 1'b0;
    end
    else if (power_up)
    begin
      backlight_supply <= 1'b1;
      if (step_reg != 8'hff)
        step_reg <= step_reg + 8'h01;
      if (step_reg == 8'(PWM_GAP))
        run_reg <= 1'b1;
      if (step_reg == 8'(PWM_GAP + ON_GAP))
        backlight_on_ctl <= 1'b1;
    end
    else
    begin
      step_reg <= 8'h00;
      if (backlight_on_ctl)
        backlight_on_ctl <= 1'b0;
      else if (run_reg)
        run_reg <= 1'b0;
      else
        backlight_supply <= 1'b0;
    end
endmodule // host_board_model

// >>> testbench/tb_top.sv
// self-checking bench for the backlight power sequencer
`timescale 1ns/1ns
module tb_top;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic power_up = 1'b0;
  logic on_extra = 1'b0;
  logic mode_2d = 1'b1;
  logic local_dim_select = 1'b0;
  logic local_dim_pulse = 1'b0;
  logic protect_trip = 1'b0;
  logic [7:0] lane_lock = 8'h00;
  logic lane_valid = 1'b0;
  logic [239:0] lane_data = '0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic rd_seen = 1'b0;
  logic [31:0] rd_data;
  logic [239:0] pixel_group;
  logic irq, lamp_drive, fault_out, fault_oe, lock_out, lock_oe, pixel_valid;
  logic supply, pulse, host_on;
  logic [31:0] seed = 32'h5d32;
  logic [31:0] rd_exp_q[$];
  logic [31:0] rd_msk_q[$];
  logic [239:0] pix_q[$];
  int miscompares = 0;
  int num_checks = 0;
  int highs;
  always #2 clock = ~clock;
  host_board_model u_host (.clock(clock), .rst_b(rst_b), .power_up(power_up),
    .backlight_supply(supply), .external_dimming_pulse(pulse), .backlight_on_ctl(host_on));
  backlight_power_sequencer #(.PWM_DELAY_CYC(20), .ON_DELAY_CYC(40), .OFF_TIME_CYC(40),
    .TURN_ON_CYC(30)) u_dut (.clock(clock), .rst_b(rst_b), .backlight_supply(supply),
    .external_dimming_pulse(pulse), .backlight_on_ctl(host_on | on_extra), .mode_2d(mode_2d),
    .local_dim_select(local_dim_select), .local_dim_pulse(local_dim_pulse),
    .protect_trip(protect_trip), .lane_lock(lane_lock), .lane_valid(lane_valid),
    .lane_data(lane_data), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .irq(irq), .lamp_drive(lamp_drive), .fault_flag_out(fault_out),
    .fault_flag_oe(fault_oe), .link_lock_indicator_out(lock_out),
    .link_lock_indicator_oe(lock_oe), .pixel_group(pixel_group), .pixel_valid(pixel_valid));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [239:0] seen, input logic [239:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic check1(input logic seen, input logic exp);
    check({239'h0, seen}, {239'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  // the note is masked here so the watcher compares only meaningful fields
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clock);
    rd_en <= 1'b1;
    addr <= a;
    rd_msk_q.push_back(m);
    rd_exp_q.push_back(e & m);
    @(posedge clock);
    rd_en <= 1'b0;
  endtask
  // lane k word lands as pixel k+1, so the group equals the lane vector
  task automatic lanes(input int n);
    logic [239:0] d;
    repeat (n)
    begin
      @(posedge clock);
      for (int k = 0; k < 8; k++)
        d[k*30 +: 30] = 30'(xs());
      lane_valid <= 1'b1;
      lane_data <= d;
      pix_q.push_back(d);
    end
    @(posedge clock);
    lane_valid <= 1'b0;
  endtask
  // any 16-cycle span of the host waveform holds exactly 8 high cycles
  task automatic count_lamp(input int want);
    highs = 0;
    repeat (16)
    begin
      @(posedge clock);
      highs += int'(lamp_drive === 1'b1);
    end
    check(240'(highs), 240'(want));
  endtask
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // oldest note is taken off whenever read data or a pixel group appears
  always @(posedge clock)
  begin
    if (rd_seen)
    begin
      check(240'(rd_data & rd_msk_q[0]), 240'(rd_exp_q.pop_front()));
      void'(rd_msk_q.pop_front());
    end
    if (pixel_valid)
      check(pixel_group, pix_q.pop_front());
    rd_seen <= rd_en;
  end
  // hang guard
  initial
  begin
    #40000;
    miscompares++;
    tally_and_finish();
  end
  initial
  begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    rd(bl_seq_pkg::STATUS_OFS, 32'hf, 32'h0);
    rd(bl_seq_pkg::ENABLE_OFS, 32'hf, 32'h0);
    rd(bl_seq_pkg::CONTROL_OFS, 32'h1, 32'h1);
    rd(bl_seq_pkg::CLEAR_OFS, 32'hffffffff, 32'h0);
    rd(8'h14, 32'hffffffff, 32'h0);
    check1(fault_oe, 1'b1);
    check1(lock_oe, 1'b0);
    lanes(6);
    lane_lock <= 8'hff;
    wr(bl_seq_pkg::ENABLE_OFS, 32'h8);
    cyc(3);
    check1(lock_oe, 1'b1);
    check1(lock_out, 1'b0);
    check1(irq, 1'b1);
    wr(bl_seq_pkg::CLEAR_OFS, 32'h8);
    cyc(2);
    check1(irq, 1'b0);
    lane_lock <= 8'(xs()) & 8'h7f;
    cyc(3);
    check1(lock_oe, 1'b0);
    // on control with no supply must be refused and flagged
    on_extra <= 1'b1;
    cyc(2);
    on_extra <= 1'b0;
    cyc(2);
    rd(bl_seq_pkg::STATUS_OFS, 32'h2, 32'h2);
    wr(bl_seq_pkg::CLEAR_OFS, 32'hf);
    power_up <= 1'b1;
    cyc(160);
    rd(bl_seq_pkg::STATE_OFS, 32'h1ff, 32'h144);
    rd(bl_seq_pkg::STATUS_OFS, 32'h6, 32'h0);
    count_lamp(8);
    mode_2d <= 1'b0;
    cyc(3);
    count_lamp(16);
    mode_2d <= 1'b1;
    local_dim_select <= 1'b1;
    local_dim_pulse <= xs() > 32'h7fffffff;
    cyc(3);
    check1(lamp_drive, local_dim_pulse);
    rd(bl_seq_pkg::STATE_OFS, 32'hc0, 32'hc0);
    wr(bl_seq_pkg::ENABLE_OFS, 32'h1);
    protect_trip <= 1'b1;
    cyc(1);
    protect_trip <= 1'b0;
    cyc(3);
    check1(fault_oe, 1'b0);
    check1(fault_out, 1'b0);
    check1(irq, 1'b1);
    rd(bl_seq_pkg::STATE_OFS, 32'h17, 32'h15);
    power_up <= 1'b0;
    cyc(8);
    rd(bl_seq_pkg::STATE_OFS, 32'h7, 32'h0);
    check1(fault_oe, 1'b1);
    wr(bl_seq_pkg::CLEAR_OFS, 32'hf);
    cyc(2);
    check1(irq, 1'b0);
    // early on control in ready, well before the on delay: refused, flagged, stays ready
    power_up <= 1'b1;
    cyc(40);
    on_extra <= 1'b1;
    cyc(1);
    on_extra <= 1'b0;
    rd(bl_seq_pkg::STATE_OFS, 32'h7, 32'h2);
    rd(bl_seq_pkg::STATUS_OFS, 32'h2, 32'h2);
    power_up <= 1'b0;
    cyc(4);
    tally_and_finish();
  end
endmodule // tb_top
